// file: inc_consts.svh
`ifndef INC_CONSTS_SVH
`define INC_CONSTS_SVH
// ****************************************************************
// Register map (byte offsets, one aligned word each)
// ****************************************************************
`define INC_ADDR_W        8
`define INC_OFS_ICR_LAST  8'h7c
`define INC_OFS_EDGE      8'h80
`define INC_OFS_PSW       8'h84
`define INC_OFS_NMI_PC    8'h88
`define INC_OFS_NMI_ST    8'h8c
`define INC_OFS_INT_PC    8'h90
`define INC_OFS_INT_ST    8'h94
`define INC_OFS_CAUSE     8'h98
`define INC_OFS_ISR       8'h9c
// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define INC_ICR_FLAG      7
`define INC_ICR_MASK      6
`define INC_ICR_RST       8'h47
`define INC_EDGE_RST      8'h00
`define INC_PSW_ID        5
`define INC_PSW_EP        6
`define INC_PSW_NP        7
`define INC_PSW_RST       32'h00000020
// ****************************************************************
// Cause codes and handler addresses
// ****************************************************************
`define INC_NMI_CAUSE     16'h0010
`define INC_NMI_VEC       32'h00000010
`define INC_INT_CAUSE0    16'h0080
`define INC_INT_VEC0      32'h00000080
`define INC_NSRC          32
`endif

// file: inc_pkg.sv
`default_nettype none
package inc_pkg;
   typedef logic [2:0]  inc_lvl_type;
   typedef logic [4:0]  inc_idx_type;
   typedef logic [31:0] inc_word_type;
endpackage : inc_pkg
`default_nettype wire

// file: inc_arb_if.sv
`default_nettype none
// Carries pending requests to the arbiter and the winner back
interface inc_arb_if;
   import inc_pkg::*;
   logic [31:0]            req;
   inc_lvl_type [31:0]     lvl;
   logic                   win_v;
   inc_idx_type            win_idx;
   inc_lvl_type            win_lvl;
   modport ctrl (output req, output lvl,
                 input win_v, input win_idx, input win_lvl);
   modport arb  (input req, input lvl,
                 output win_v, output win_idx, output win_lvl);
endinterface : inc_arb_if
`default_nettype wire

// file: inc_arbiter.sv
`default_nettype none
// Lowest level wins; among equal levels lowest source index wins
module inc_arbiter
   import inc_pkg::*;
(
   inc_arb_if.arb  arb
);
   logic        [32:0] v_c;
   inc_idx_type [32:0] i_c;
   inc_lvl_type [32:0] l_c;

   assign v_c[0] = 1'b0;
   assign i_c[0] = 5'h00;
   assign l_c[0] = 3'h7;

   // ****************************************************************
   // Compare chain, one stage per source
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_stage
         logic take;
         // Strict less-than keeps the earlier (lower default) index
         assign take = arb.req[g] &&
                       (!v_c[g] || (arb.lvl[g] < l_c[g]));
         assign v_c[g+1] = v_c[g] | arb.req[g];
         assign i_c[g+1] = take ? 5'(g) : i_c[g];
         assign l_c[g+1] = take ? arb.lvl[g] : l_c[g];
      end
   endgenerate

   assign arb.win_v   = v_c[32];
   assign arb.win_idx = i_c[32];
   assign arb.win_lvl = l_c[32];
endmodule : inc_arbiter
`default_nettype wire

// file: inc_ctrl.sv
`default_nettype none
`include "inc_consts.svh"
module inc_ctrl
   import inc_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [`INC_ADDR_W-1:0] paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  nmi_pin,
   input  wire logic [31:0]           irq_src,
   input  wire logic                  core_boundary,
   input  wire logic [31:0]           core_ret_pc,
   input  wire logic                  core_return_from_handler_instr,
   input  wire logic                  core_ei,
   input  wire logic                  core_di,
   output logic                       take_pulse,
   output logic      [31:0]           take_vector,
   output logic                       resume_pulse,
   output logic      [31:0]           resume_pc,
   output logic      [31:0]           psw_out,
   output logic                       nmi_wake
);
   // ****************************************************************
   // State
   // ****************************************************************
   logic [31:0]  flag_q;
   logic [31:0]  mask_q;
   inc_lvl_type [31:0] lvl_q;
   logic [7:0]   edge_mode_q;
   inc_word_type psw_q;
   inc_word_type nmi_pc_q;
   inc_word_type nmi_st_q;
   inc_word_type int_pc_q;
   inc_word_type int_st_q;
   inc_word_type cause_q;
   logic [7:0]   isr_q;
   logic         nmi_pend_q;
   logic         s1_q, s2_q, s3_q, pin_lvl_q;
   logic         pready_q, pslverr_q, take_q, resume_q, wake_q;
   inc_word_type prdata_q, vec_q, rpc_q;

   inc_arb_if arb_if ();

   inc_arbiter u_arb (
      .arb (arb_if.arb)
   );

   // ****************************************************************
   // APB decode
   // ****************************************************************
   logic        wr_en, rd_en, addr_ok, icr_hit;
   logic [4:0]  icr_idx;
   logic [31:0] rd_d;

   assign wr_en   = psel && penable && pready_q && pwrite && addr_ok;
   assign rd_en   = psel && penable && !pready_q;
   assign icr_hit = (paddr <= `INC_OFS_ICR_LAST);
   assign icr_idx = paddr[6:2];
   assign addr_ok = (paddr[1:0] == 2'h0) &&
                    (icr_hit || (paddr >= `INC_OFS_EDGE &&
                                 paddr <= `INC_OFS_ISR));

   // Read mux; unmapped reads as zero with an error
   always_comb begin
      rd_d = 32'h0;
      if (icr_hit)
         rd_d = {24'h0, flag_q[icr_idx], mask_q[icr_idx], 3'h0,
                 lvl_q[icr_idx]};
      else begin
         unique case (paddr)
            `INC_OFS_EDGE:   rd_d = {24'h0, edge_mode_q};
            `INC_OFS_PSW:    rd_d = psw_q;
            `INC_OFS_NMI_PC: rd_d = nmi_pc_q;
            `INC_OFS_NMI_ST: rd_d = nmi_st_q;
            `INC_OFS_INT_PC: rd_d = int_pc_q;
            `INC_OFS_INT_ST: rd_d = int_st_q;
            `INC_OFS_CAUSE:  rd_d = cause_q;
            `INC_OFS_ISR:    rd_d = {24'h0, isr_q};
            default:         rd_d = 32'h0;
         endcase
      end
   end

   // One wait state: pready rises the cycle after the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= rd_en;
         pslverr_q <= rd_en && !addr_ok;
         if (rd_en)
            prdata_q <= (pwrite || !addr_ok) ? 32'h0 : rd_d;
      end
   end

   // ****************************************************************
   // NMI pin: three-stage sampling and edge choice
   // ****************************************************************
   logic pin_settled, nmi_edge, sel_rise;
   assign sel_rise    = edge_mode_q[0];
   assign pin_settled = (s2_q == s3_q);
   assign nmi_edge    = pin_settled && (s3_q != pin_lvl_q) &&
                        (s3_q == sel_rise);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q      <= 1'b0;
         s2_q      <= 1'b0;
         s3_q      <= 1'b0;
         pin_lvl_q <= 1'b0;
         wake_q    <= 1'b0;
      end else begin
         s1_q   <= nmi_pin;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         if (pin_settled)
            pin_lvl_q <= s3_q;
         // Needs pclk running; a stopped clock must be woken upstream
         wake_q <= nmi_edge;
      end
   end

   // Edge mode: a write keeps only bit 0, bits 7:1 load zero; bit access is a read-modify-write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         edge_mode_q <= `INC_EDGE_RST;
      else if (wr_en && paddr == `INC_OFS_EDGE)
         edge_mode_q <= {7'h0, pwdata[0]};
   end

   // ****************************************************************
   // Acceptance decision
   // ****************************************************************
   logic        np, id, ep, isr_any, preempt_ok, acc_nmi, acc_int, return_from_handler_instr;
   inc_lvl_type isr_top;
   logic [7:0]  isr_clr;

   assign np = psw_q[`INC_PSW_NP];
   assign id = psw_q[`INC_PSW_ID];
   assign ep = psw_q[`INC_PSW_EP];

   // Highest active in-service level is the lowest set bit
   always_comb begin
      isr_top = 3'h7;
      isr_clr = 8'h0;
      for (int k = 7; k >= 0; k--) begin
         if (isr_q[k])
            isr_top = 3'(k);
      end
      isr_clr[isr_top] = isr_q[isr_top];
   end
   assign isr_any    = |isr_q;
   assign preempt_ok = !isr_any || (arb_if.win_lvl < isr_top);

   // Return takes the boundary; otherwise one entry at most
   assign return_from_handler_instr    = core_return_from_handler_instr;
   assign acc_nmi = core_boundary && !return_from_handler_instr && nmi_pend_q &&
                    !np;
   assign acc_int = core_boundary && !return_from_handler_instr && !acc_nmi && !np && !id &&
                    arb_if.win_v && preempt_ok;

   // Pending NMI: single bit, new edge wins over acceptance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         nmi_pend_q <= 1'b0;
      else if (nmi_edge)
         nmi_pend_q <= 1'b1;
      else if (acc_nmi)
         nmi_pend_q <= 1'b0;
   end

   // ****************************************************************
   // Per-source control registers
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_src
         logic hit;
         assign hit = wr_en && icr_hit && (icr_idx == 5'(g));
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flag_q[g] <= 1'((`INC_ICR_RST >> `INC_ICR_FLAG));
               mask_q[g] <= 1'((`INC_ICR_RST >> `INC_ICR_MASK));
               lvl_q[g]  <= 3'(`INC_ICR_RST);
            end else begin
               if (irq_src[g])
                  flag_q[g] <= 1'b1;
               else if (acc_int && arb_if.win_idx == 5'(g))
                  flag_q[g] <= 1'b0;
               else if (hit)
                  flag_q[g] <= pwdata[`INC_ICR_FLAG];
               if (hit) begin
                  mask_q[g] <= pwdata[`INC_ICR_MASK];
                  lvl_q[g]  <= pwdata[2:0];
               end
            end
         end
         assign arb_if.req[g] = flag_q[g] && !mask_q[g];
         assign arb_if.lvl[g] = lvl_q[g];
      end
   endgenerate

   // ****************************************************************
   // Status word: core instructions over software loads
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         psw_q <= `INC_PSW_RST;
      else if (acc_nmi) begin
         psw_q[`INC_PSW_NP] <= 1'b1;
         psw_q[`INC_PSW_ID] <= 1'b1;
         psw_q[`INC_PSW_EP] <= 1'b0;
      end else if (acc_int) begin
         psw_q[`INC_PSW_ID] <= 1'b1;
         psw_q[`INC_PSW_EP] <= 1'b0;
      end else if (return_from_handler_instr)
         psw_q <= (!ep && np) ? nmi_st_q : int_st_q;
      else if (core_di)
         psw_q[`INC_PSW_ID] <= 1'b1;
      else if (core_ei)
         psw_q[`INC_PSW_ID] <= 1'b0;
      else if (wr_en && paddr == `INC_OFS_PSW)
         psw_q <= pwdata;
   end

   // NMI save registers; software may also load them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_pc_q <= 32'h0;
         nmi_st_q <= 32'h0;
      end else if (acc_nmi) begin
         nmi_pc_q <= core_ret_pc;
         nmi_st_q <= psw_q;
      end else if (wr_en) begin
         if (paddr == `INC_OFS_NMI_PC)
            nmi_pc_q <= pwdata;
         if (paddr == `INC_OFS_NMI_ST)
            nmi_st_q <= pwdata;
      end
   end

   // Maskable save registers; nesting handlers reload them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_pc_q <= 32'h0;
         int_st_q <= 32'h0;
      end else if (acc_int) begin
         int_pc_q <= core_ret_pc;
         int_st_q <= psw_q;
      end else if (wr_en) begin
         if (paddr == `INC_OFS_INT_PC)
            int_pc_q <= pwdata;
         if (paddr == `INC_OFS_INT_ST)
            int_st_q <= pwdata;
      end
   end

   // Cause register: each entry kind owns one halfword
   logic [15:0] int_cause;
   assign int_cause = `INC_INT_CAUSE0 + {7'h0, arb_if.win_idx, 4'h0};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         cause_q <= 32'h0;
      else if (acc_nmi)
         cause_q[31:16] <= `INC_NMI_CAUSE;
      else if (acc_int)
         cause_q[15:0] <= int_cause;
   end

   // In-service levels; only a maskable return clears one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         isr_q <= 8'h0;
      else if (acc_int)
         isr_q[arb_if.win_lvl] <= 1'b1;
      else if (return_from_handler_instr && !ep && !np)
         isr_q <= isr_q & ~isr_clr;
   end

   // ****************************************************************
   // Core-facing outputs
   // ****************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         take_q   <= 1'b0;
         vec_q    <= 32'h0;
         resume_q <= 1'b0;
         rpc_q    <= 32'h0;
      end else begin
         take_q   <= acc_nmi || acc_int;
         resume_q <= return_from_handler_instr;
         if (acc_nmi)
            vec_q <= `INC_NMI_VEC;
         else if (acc_int)
            vec_q <= `INC_INT_VEC0 + {23'h0, arb_if.win_idx, 4'h0};
         if (return_from_handler_instr)
            rpc_q <= (!ep && np) ? nmi_pc_q : int_pc_q;
      end
   end

   assign prdata       = prdata_q;
   assign pready       = pready_q;
   assign pslverr      = pslverr_q;
   assign take_pulse   = take_q;
   assign take_vector  = vec_q;
   assign resume_pulse = resume_q;
   assign resume_pc    = rpc_q;
   assign psw_out      = psw_q;
   assign nmi_wake     = wake_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_nmi_wins_int: assert property (acc_nmi |-> !acc_int)
      else $error("maskable taken beside nmi");
   a_nmi_edge_pend: assert property (nmi_edge |=> nmi_pend_q)
      else $error("nmi edge not pended");
   a_nmi_held_active: assert property (np |-> !acc_nmi && !acc_int)
      else $error("acceptance while nmi active");
   a_nmi_entry_state: assert property (acc_nmi |=>
      psw_q[`INC_PSW_NP] && psw_q[`INC_PSW_ID] && !psw_q[`INC_PSW_EP] &&
      take_q && vec_q == `INC_NMI_VEC)
      else $error("nmi entry state wrong");
   a_nmi_cause_save: assert property (acc_nmi |=>
      cause_q[31:16] == `INC_NMI_CAUSE &&
      nmi_pc_q == $past(core_ret_pc) && nmi_st_q == $past(psw_q))
      else $error("nmi save or cause wrong");
   a_int_entry_save: assert property (acc_int |=>
      int_pc_q == $past(core_ret_pc) && psw_q[`INC_PSW_ID] &&
      cause_q[15:0] == $past(int_cause))
      else $error("maskable entry wrong");
   a_int_gate_level: assert property (acc_int |->
      !id && (!isr_any || arb_if.win_lvl < isr_top))
      else $error("maskable taken against level");
   a_return_from_handler_instr_nmi_path: assert property (return_from_handler_instr && !ep && np |=>
      resume_q && rpc_q == $past(nmi_pc_q) && psw_q == $past(nmi_st_q))
      else $error("nmi return wrong");
   a_isr_top_clear: assert property (return_from_handler_instr && !ep && !np && isr_any |=>
      isr_q == ($past(isr_q) & ~$past(isr_clr)))
      else $error("in-service clear wrong");
   a_take_boundary: assert property (take_q |-> $past(core_boundary))
      else $error("take off boundary");

   c_nmi_taken: cover property (acc_nmi);
   c_nmi_after_pend: cover property (np && nmi_pend_q ##[1:50] acc_nmi);
   c_int_nested: cover property (acc_int && isr_any);
   c_return_from_handler_instr_int: cover property (return_from_handler_instr && !np && isr_any);
endmodule : inc_ctrl
`default_nettype wire

// file: inc_core_model.sv
`default_nettype none
// ****************************************************************
// Core and request-source model
// ****************************************************************
module inc_core_model
   import inc_pkg::*;
#(
   parameter logic [31:0] RET_PC = 32'h00001234
)(
   input  wire logic        pclk,
   output logic             nmi_pin,
   output logic [31:0]      irq_src,
   output logic             core_boundary,
   output logic [31:0]      core_ret_pc,
   output logic             core_return_from_handler_instr,
   output logic             core_ei,
   output logic             core_di
);
   // Idle levels at time zero; boundary open so entries go promptly
   initial begin
      core_ret_pc = RET_PC;
      nmi_pin = 1'b0;
      irq_src = '0;
      core_boundary = 1'b1;
      core_return_from_handler_instr = 1'b0;
      core_ei = 1'b0;
      core_di = 1'b0;
   end
   // One-cycle core strobe: 0 return, 1 unmask all, 2 mask all
   task automatic strobe(input int k);
      @(posedge pclk);
      core_return_from_handler_instr <= (k == 0);
      core_ei <= (k == 1);
      core_di <= (k == 2);
      @(posedge pclk);
      core_return_from_handler_instr <= 1'b0;
      core_ei <= 1'b0;
      core_di <= 1'b0;
   endtask : strobe
   // One-cycle request pulse on every set bit
   task automatic raise(input logic [31:0] m);
      @(posedge pclk);
      irq_src <= m;
      @(posedge pclk);
      irq_src <= '0;
   endtask : raise
   // Spacing first so each level outlasts the sampling flops
   task automatic nmi_set(input logic v);
      repeat (5) @(posedge pclk);
      nmi_pin <= v;
   endtask : nmi_set
   // Moving return address, so every save is seen to follow the core
   task automatic set_pc(input logic [31:0] v);
      @(posedge pclk);
      core_ret_pc <= v;
   endtask : set_pc
   // Low boundary stalls the core, as a long instruction would
   task automatic set_bound(input logic v);
      @(posedge pclk);
      core_boundary <= v;
   endtask : set_bound
endmodule : inc_core_model
`default_nettype wire

// file: nmi_and_maskable_interrupt_handling_bench.sv
`default_nettype none
`include "inc_consts.svh"
module nmi_and_maskable_interrupt_handling_bench
   import inc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [31:0] RET_PC = 32'h00001234;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        nmi_pin, core_boundary, core_return_from_handler_instr, core_ei, core_di;
   logic        take_pulse, resume_pulse, nmi_wake, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, irq_src, core_ret_pc, take_vector;
   logic [31:0] resume_pc, psw_out, rd;
   int          num_errors = 0, checks = 0, wake_cnt = 0;
   inc_ctrl uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin),
      .irq_src(irq_src), .core_boundary(core_boundary),
      .core_ret_pc(core_ret_pc), .core_return_from_handler_instr(core_return_from_handler_instr),
      .core_ei(core_ei), .core_di(core_di), .take_pulse(take_pulse),
      .take_vector(take_vector), .resume_pulse(resume_pulse),
      .resume_pc(resume_pc), .psw_out(psw_out), .nmi_wake(nmi_wake)
   );
   inc_core_model #(.RET_PC(RET_PC)) core (
      .pclk(pclk), .nmi_pin(nmi_pin), .irq_src(irq_src),
      .core_boundary(core_boundary), .core_ret_pc(core_ret_pc),
      .core_return_from_handler_instr(core_return_from_handler_instr), .core_ei(core_ei), .core_di(core_di)
   );
   // 10 MHz clock
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // Wake pulses counted on the settled half of the cycle
   always @(negedge pclk) begin
      if (nmi_wake === 1'b1) wake_cnt++;
   end
   // ****************************************************************
   // Helpers
   // ****************************************************************
   task automatic close_out();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   task automatic give_up();
      num_errors++;
      $display("ERROR %0t wait ran out", $time);
      close_out();
   endtask : give_up
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // APB transfer; answer taken at the rising edge that samples pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) give_up();
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc
   // Bounded wait for an entry (k 0) or a return (k 1), then its address
   task automatic wait_ev(input int k, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
         if (n > 60) give_up();
      end while ((k == 0 ? take_pulse : resume_pulse) !== 1'b1);
      chk(k == 0 ? take_vector : resume_pc, v);
   endtask : wait_ev
   // Entries must stay absent for n cycles
   task automatic no_take(input int n);
      int c;
      c = 0;
      repeat (n) begin
         @(negedge pclk);
         if (take_pulse !== 1'b0) c++;
      end
      chk(32'(c), 32'h0);
   endtask : no_take
   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      rdc(`INC_OFS_PSW, `INC_PSW_RST);
      rdc(`INC_OFS_EDGE, 32'h0);
      rdc(8'h00, 32'h47);
      rdc(`INC_OFS_ICR_LAST, 32'h47);
      rdc(`INC_OFS_ISR, 32'h0);
      apb(1'b0, 8'ha0, 32'h0);
      chk({31'h0, er}, 32'h1);
      // A refused misaligned write must leave its neighbour alone
      apb(1'b1, 8'h06, 32'h0);
      chk({31'h0, er}, 32'h1);
      rdc(8'h04, 32'h47);
      // Saved registers take software loads on every data bit
      apb(1'b1, `INC_OFS_NMI_PC, 32'hffffffff);
      rdc(`INC_OFS_NMI_PC, 32'hffffffff);
      apb(1'b1, `INC_OFS_INT_ST, 32'h5555aaaa);
      rdc(`INC_OFS_INT_ST, 32'h5555aaaa);
   endtask : t_reset
   // Sources 1, 2, 5, 9 pend together at levels 4, 3, 3, 1
   task automatic t_order();
      apb(1'b1, 8'h04, 32'h04);
      apb(1'b1, 8'h08, 32'h03);
      apb(1'b1, 8'h14, 32'h03);
      apb(1'b1, 8'h24, 32'h01);
      core.raise(32'h00000226);
      no_take(10);
      rdc(8'h24, 32'h81);
      core.set_bound(1'b0);
      core.strobe(1);
      no_take(6);
      core.set_bound(1'b1);
      wait_ev(0, 32'h110);
      chk(psw_out, 32'h20);
      rdc(`INC_OFS_CAUSE, 32'h110);
      rdc(8'h24, 32'h01);
      rdc(`INC_OFS_INT_PC, RET_PC);
      rdc(`INC_OFS_INT_ST, 32'h0);
      rdc(`INC_OFS_ISR, 32'h02);
      core.strobe(0);
      wait_ev(1, RET_PC);
      wait_ev(0, 32'ha0);
      core.strobe(0);
      wait_ev(0, 32'hd0);
      core.strobe(0);
      wait_ev(0, 32'h90);
      core.strobe(0);
      wait_ev(1, RET_PC);
      rdc(`INC_OFS_ISR, 32'h0);
   endtask : t_order
   // Same level must not nest, a higher level must; software keeps saves
   task automatic t_nest();
      core.set_pc(32'h00001000);
      core.raise(32'h4);
      wait_ev(0, 32'ha0);
      rdc(`INC_OFS_INT_PC, 32'h00001000);
      core.strobe(1);
      core.raise(32'h20);
      no_take(10);
      core.set_pc(32'h00002000);
      core.raise(32'h200);
      wait_ev(0, 32'h110);
      rdc(`INC_OFS_ISR, 32'h0a);
      core.strobe(0);
      wait_ev(1, 32'h00002000);
      no_take(6);
      // Outer handler masks, then puts back what the nested entry overwrote
      core.strobe(2);
      apb(1'b1, `INC_OFS_INT_PC, 32'h00001000);
      apb(1'b1, `INC_OFS_INT_ST, 32'h0);
      core.strobe(0);
      wait_ev(1, 32'h00001000);
      wait_ev(0, 32'hd0);
      core.strobe(0);
      wait_ev(1, 32'h00002000);
      core.strobe(2);
   endtask : t_nest
   // Every source in turn: own control register, pulse and handler
   task automatic t_sweep();
      core.strobe(1);
      for (int i = 0; i < `INC_NSRC; i++) begin
         core.set_pc(32'h00004000 | 32'(i << 2));
         apb(1'b1, 8'(i << 2), 32'h07);
         core.raise(32'h1 << i);
         wait_ev(0, `INC_INT_VEC0 + 32'(i << 4));
         core.strobe(0);
         wait_ev(1, 32'h00004000 | 32'(i << 2));
      end
      core.strobe(2);
   endtask : t_sweep
   // Both edge choices, taken while masked, extra edges folded
   task automatic t_nmi();
      for (logic [31:0] e = 0; e < 2; e++) begin
         core.set_pc(RET_PC + (e << 2));
         apb(1'b1, `INC_OFS_EDGE, e);
         rdc(`INC_OFS_EDGE, e);
         core.nmi_set(~e[0]);
         no_take(8);
         core.nmi_set(e[0]);
         wait_ev(0, `INC_NMI_VEC);
         chk(psw_out, 32'ha0);
         rdc(`INC_OFS_NMI_PC, RET_PC + (e << 2));
         rdc(`INC_OFS_NMI_ST, 32'h20);
         apb(1'b0, `INC_OFS_CAUSE, 32'h0);
         chk({16'h0, rd[31:16]}, {16'h0, `INC_NMI_CAUSE});
         core.raise(32'h4);
         repeat (2) begin
            core.nmi_set(~e[0]);
            core.nmi_set(e[0]);
         end
         no_take(10);
         // First pass ends service by return, second by a status load
         if (e == 0) begin
            core.strobe(0);
            wait_ev(1, RET_PC);
         end else begin
            apb(1'b1, `INC_OFS_PSW, 32'h20);
         end
         wait_ev(0, `INC_NMI_VEC);
         core.strobe(0);
         no_take(12);
      end
   endtask : t_nmi
   // Main sequence
   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_order();
      t_nest();
      t_sweep();
      t_nmi();
      chk(32'(wake_cnt != 0), 32'h1);
      close_out();
   end
endmodule : nmi_and_maskable_interrupt_handling_bench
`default_nettype wire
